// file: logic/msc_pkg.sv
`default_nettype none
// ==========================================
// Shared widths, codes and counts
package msc_pkg;
	localparam int DATA_W  = 16;
	localparam int PROD_W  = 33;
	localparam int ACC_W   = 40;
	localparam int SHORT_W = 5;
	localparam int LONG_W  = 15;
	localparam int IDX_W   = 4;
	localparam int STAT_W  = 5;
	localparam int CNT_W   = 3;
	localparam int NIB_W   = 4;

	// Status bit positions
	localparam int STAT_C  = 0;
	localparam int STAT_DC = 1;
	localparam int STAT_N  = 2;
	localparam int STAT_OV = 3;
	localparam int STAT_Z  = 4;

	localparam logic [STAT_W-1:0] STAT_RESET   = 5'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO    = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_ONE     = 16'h0001;
	localparam logic [DATA_W-1:0] MOST_NEG     = 16'h8000;
	localparam logic [NIB_W-1:0]  NIB_ZERO     = 4'h0;
	localparam logic [LONG_W-1:0] LOOP_ZERO    = 15'h0000;
	localparam logic [LONG_W-1:0] LOOP_STEP    = 15'h0001;
	localparam logic [SHORT_W-1:0] SHORT_ZERO  = 5'h00;

	// Instruction cycle counts
	localparam logic [CNT_W-1:0] CYC_SINGLE     = 3'h1;
	localparam logic [CNT_W-1:0] CYC_DOUBLE     = 3'h2;
	localparam logic [CNT_W-1:0] CYC_CALL       = 3'h4;
	localparam logic [CNT_W-1:0] CYC_IRET       = 3'h6;
	localparam logic [CNT_W-1:0] CYC_IRET_SHORT = 3'h5;
	localparam logic [CNT_W-1:0] CYC_PERIPH     = 3'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO       = 3'h0;

	localparam logic POWER_SEL_SLEEP = 1'b0;

	typedef enum logic [13:0] {
		OP_PRODUCT       = 14'h0001,
		OP_PRODUCT_LOW   = 14'h0002,
		OP_SIGN_INVERT   = 14'h0004,
		OP_POP           = 14'h0008,
		OP_POP_DOUBLE    = 14'h0010,
		OP_POP_SHADOW    = 14'h0020,
		OP_PUSH          = 14'h0040,
		OP_PUSH_DOUBLE   = 14'h0080,
		OP_PUSH_SHADOW   = 14'h0100,
		OP_LOW_POWER     = 14'h0200,
		OP_REPEAT        = 14'h0400,
		OP_RELATIVE_CALL = 14'h0800,
		OP_IRET          = 14'h1000,
		OP_OTHER         = 14'h2000
	} msc_op_e;

	typedef enum logic [2:0] {
		DK_PAIR    = 3'h0,
		DK_SINGLE  = 3'h1,
		DK_ACC     = 3'h2,
		DK_FILE    = 3'h3,
		DK_DEFAULT = 3'h4
	} msc_dest_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_HOLD = 2'h2
	} msc_state_e;
endpackage : msc_pkg
`default_nettype wire

// file: logic/msc_mult.sv
`default_nettype none
// ==========================================
// Mixed-signedness 16x16 multiplier
module msc_mult
	import msc_pkg::*;
(
	input  wire logic [DATA_W-1:0] a,
	input  wire logic [DATA_W-1:0] b,
	input  wire logic              a_signed,
	input  wire logic              b_signed,
	output logic      [PROD_W-1:0] prod
);
	logic signed [DATA_W:0]     ax;
	logic signed [DATA_W:0]     bx;
	logic signed [2*DATA_W+1:0] full;

	// One guard bit per operand lets one signed multiplier cover all four forms
	assign ax   = {a_signed & a[DATA_W-1], a};
	assign bx   = {b_signed & b[DATA_W-1], b};
	assign full = ax * bx;
	assign prod = full[PROD_W-1:0];
endmodule : msc_mult
`default_nettype wire

// file: logic/msc_negate.sv
`default_nettype none
// ==========================================
// Two's-complement negate with flags
module msc_negate
	import msc_pkg::*;
(
	input  wire logic [DATA_W-1:0] operand,
	output logic      [DATA_W-1:0] result,
	output logic      [STAT_W-1:0] flags
);
	// Complement plus one
	assign result = (~operand) + DATA_ONE;

	// Carries out only when the operand is zero (whole word or low nibble)
	assign flags[STAT_C]  = (operand == DATA_ZERO);
	assign flags[STAT_DC] = (operand[NIB_W-1:0] == NIB_ZERO);
	assign flags[STAT_N]  = result[DATA_W-1];
	assign flags[STAT_OV] = (operand == MOST_NEG);
	assign flags[STAT_Z]  = (result == DATA_ZERO);
endmodule : msc_negate
`default_nettype wire

// file: logic/msc_exec.sv
`default_nettype none
module msc_exec
	import msc_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	input  wire logic                issue,
	input  wire msc_op_e             op,
	input  wire logic                base_signed,
	input  wire logic                src_signed,
	input  wire logic                use_const,
	input  wire msc_dest_e           dest_kind,
	input  wire logic [IDX_W-1:0]    dest_idx,
	input  wire logic                acc_sel,
	input  wire logic [DATA_W-1:0]   base_working_reg,
	input  wire logic [DATA_W-1:0]   source_working_reg,
	input  wire logic [DATA_W-1:0]   source_hi_reg,
	input  wire logic [SHORT_W-1:0]  short_const_operand,
	input  wire logic [LONG_W-1:0]   long_const_operand,
	input  wire logic                count_from_reg,
	input  wire logic [DATA_W-1:0]   stack_top,
	input  wire logic [DATA_W-1:0]   stack_next,
	input  wire logic                power_select_const,
	input  wire logic                periph_access,
	input  wire logic                short_return,
	input  wire logic                wdt_timeout_evt,
	output logic                     ready,
	output logic                     wb_en,
	output msc_dest_e                wb_kind,
	output logic      [IDX_W-1:0]    wb_idx,
	output logic      [DATA_W-1:0]   wb_lo,
	output logic                     wb_hi_en,
	output logic      [DATA_W-1:0]   wb_hi,
	output logic                     acc_en,
	output logic                     acc_sel_out,
	output logic      [ACC_W-1:0]    acc_data,
	output logic                     stk_push,
	output logic      [DATA_W-1:0]   stk_push_data,
	output logic                     stk_pop,
	output logic      [STAT_W-1:0]   status,
	output logic                     sleep_req,
	output logic                     idle_req,
	output logic                     watchdog_timeout_flag,
	output logic                     sleep_flag,
	output logic                     stack_frame_active_flag,
	output logic                     repeat_active,
	output logic      [LONG_W-1:0]   repeat_left
);
	// ==========================================
	// Datapath
	msc_state_e          state;
	logic [CNT_W-1:0]    hold_left;
	logic [CNT_W-1:0]    next_extra;
	logic                accept;
	logic [DATA_W-1:0]   mul_b;
	logic                mul_b_signed;
	logic [PROD_W-1:0]   prod;
	logic [DATA_W-1:0]   neg_res;
	logic [STAT_W-1:0]   neg_flags;
	logic [STAT_W-1:0]   shadow;
	logic                second_push;
	logic                second_pop;
	logic [DATA_W-1:0]   push_hi;

	// Requests are only taken while idle; a busy cycle simply ignores issue
	assign ready  = (state == ST_IDLE);
	assign accept = issue && ready;

	// Literal is zero-extended and never treated as signed
	assign mul_b        = use_const ? {{(DATA_W-SHORT_W){1'b0}}, short_const_operand}
	                                : source_working_reg;
	assign mul_b_signed = src_signed && !use_const;

	msc_mult u_mult (
		.a        (base_working_reg),
		.b        (mul_b),
		.a_signed (base_signed),
		.b_signed (mul_b_signed),
		.prod     (prod)
	);

	msc_negate u_negate (
		.operand (source_working_reg),
		.result  (neg_res),
		.flags   (neg_flags)
	);

	// ==========================================
	// Cycle accounting
	// Extra cycles beyond the first, per operation
	always_comb begin
		case (op)
			OP_POP_DOUBLE, OP_PUSH_DOUBLE: next_extra = CYC_DOUBLE - CYC_SINGLE;
			OP_RELATIVE_CALL:             next_extra = CYC_CALL - CYC_SINGLE;
			OP_IRET:                      next_extra = short_return
			                                         ? CYC_IRET_SHORT - CYC_SINGLE
			                                         : CYC_IRET - CYC_SINGLE;
			default:                      next_extra = CNT_ZERO;
		endcase
		// Off-core register reads stall one more cycle
		if (periph_access) begin
			next_extra = next_extra + CYC_PERIPH;
		end
	end

	// Busy state machine
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state     <= ST_IDLE;
			hold_left <= CNT_ZERO;
		end else begin
			case (state)
				ST_IDLE: begin
					if (accept && next_extra != CNT_ZERO) begin
						state     <= ST_HOLD;
						hold_left <= next_extra;
					end
				end
				ST_HOLD: begin
					hold_left <= hold_left - CYC_SINGLE;
					if (hold_left == CYC_SINGLE) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state     <= ST_IDLE;
					hold_left <= CNT_ZERO;
				end
			endcase
		end
	end

	// ==========================================
	// Stack traffic
	// Second word of a double transfer follows one cycle after the first
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stk_push      <= 1'b0;
			stk_pop       <= 1'b0;
			stk_push_data <= DATA_ZERO;
			second_push   <= 1'b0;
			second_pop    <= 1'b0;
			push_hi       <= DATA_ZERO;
		end else begin
			stk_push    <= 1'b0;
			stk_pop     <= 1'b0;
			second_push <= 1'b0;
			second_pop  <= 1'b0;
			if (accept && (op == OP_PUSH || op == OP_PUSH_DOUBLE)) begin
				stk_push      <= 1'b1;
				stk_push_data <= source_working_reg;
				second_push   <= (op == OP_PUSH_DOUBLE);
				push_hi       <= source_hi_reg;
			end else if (accept && (op == OP_POP || op == OP_POP_DOUBLE)) begin
				stk_pop    <= 1'b1;
				second_pop <= (op == OP_POP_DOUBLE);
			end else if (second_push) begin
				stk_push      <= 1'b1;
				stk_push_data <= push_hi;
			end else if (second_pop) begin
				stk_pop <= 1'b1;
			end
		end
	end

	// ==========================================
	// Result writeback
	// One-cycle write strobes; data holds until the next write
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wb_en       <= 1'b0;
			wb_kind     <= DK_SINGLE;
			wb_idx      <= '0;
			wb_lo       <= DATA_ZERO;
			wb_hi_en    <= 1'b0;
			wb_hi       <= DATA_ZERO;
			acc_en      <= 1'b0;
			acc_sel_out <= 1'b0;
			acc_data    <= '0;
		end else begin
			wb_en    <= 1'b0;
			wb_hi_en <= 1'b0;
			acc_en   <= 1'b0;
			if (accept) begin
				wb_idx <= dest_idx;
				case (op)
					OP_PRODUCT: begin
						if (dest_kind == DK_ACC) begin
							acc_en      <= 1'b1;
							acc_sel_out <= acc_sel;
							acc_data    <= {{(ACC_W-PROD_W){prod[PROD_W-1]}}, prod};
						end else begin
							wb_en    <= 1'b1;
							wb_kind  <= dest_kind;
							wb_lo    <= prod[DATA_W-1:0];
							wb_hi_en <= (dest_kind == DK_PAIR);
							wb_hi    <= prod[2*DATA_W-1:DATA_W];
						end
					end
					OP_PRODUCT_LOW: begin
						wb_en   <= 1'b1;
						wb_kind <= DK_SINGLE;
						wb_lo   <= prod[DATA_W-1:0];
					end
					OP_SIGN_INVERT: begin
						wb_en   <= 1'b1;
						wb_kind <= dest_kind;
						wb_lo   <= neg_res;
					end
					OP_POP: begin
						wb_en   <= 1'b1;
						wb_kind <= dest_kind;
						wb_lo   <= stack_top;
					end
					OP_POP_DOUBLE: begin
						// Top word was pushed last, so it lands in the higher register
						wb_en    <= 1'b1;
						wb_kind  <= DK_PAIR;
						wb_lo    <= stack_next;
						wb_hi_en <= 1'b1;
						wb_hi    <= stack_top;
					end
					default: begin
						wb_en <= 1'b0;
					end
				endcase
			end
		end
	end

	// ==========================================
	// Status flags and shadow copy
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			status <= STAT_RESET;
			shadow <= STAT_RESET;
		end else if (accept) begin
			if (op == OP_SIGN_INVERT) begin
				status <= neg_flags;
			end else if (op == OP_PUSH_SHADOW) begin
				shadow <= status;
			end else if (op == OP_POP_SHADOW) begin
				status <= shadow;
			end
		end
	end

	// ==========================================
	// Power entry, watchdog and frame flags
	// A watchdog event in the same cycle as power entry keeps its flag set
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sleep_req               <= 1'b0;
			idle_req                <= 1'b0;
			watchdog_timeout_flag   <= 1'b0;
			sleep_flag              <= 1'b0;
			stack_frame_active_flag <= 1'b0;
		end else begin
			sleep_req <= accept && op == OP_LOW_POWER && power_select_const == POWER_SEL_SLEEP;
			idle_req  <= accept && op == OP_LOW_POWER && power_select_const != POWER_SEL_SLEEP;
			if (wdt_timeout_evt) begin
				watchdog_timeout_flag <= 1'b1;
			end else if (accept && op == OP_LOW_POWER) begin
				watchdog_timeout_flag <= 1'b0;
			end
			if (accept && op == OP_LOW_POWER && power_select_const == POWER_SEL_SLEEP) begin
				sleep_flag <= 1'b1;
			end
			if (accept && op == OP_RELATIVE_CALL) begin
				stack_frame_active_flag <= 1'b1;
			end else if (accept && op == OP_IRET) begin
				stack_frame_active_flag <= 1'b0;
			end
		end
	end

	// ==========================================
	// Loop prefix counter
	// Holds the executions still owed after the next one
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			repeat_left <= LOOP_ZERO;
		end else if (accept && op == OP_REPEAT) begin
			repeat_left <= count_from_reg ? source_working_reg[LONG_W-1:0]
			                              : long_const_operand;
		end else if (accept && repeat_left != LOOP_ZERO) begin
			repeat_left <= repeat_left - LOOP_STEP;
		end
	end

	assign repeat_active = (repeat_left != LOOP_ZERO);

	// ==========================================
	// Checks
	pair_write_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		accept && op == OP_PRODUCT && dest_kind == DK_PAIR
		|=> wb_en && wb_hi_en && {wb_hi, wb_lo} == $past(prod[2*DATA_W-1:0]))
		else $error("pair product not written");
	acc_flags_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		accept && op == OP_PRODUCT && dest_kind == DK_ACC
		|=> acc_en && !wb_en && $stable(status))
		else $error("accumulator product wrong");
	const_unsigned_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		accept && op == OP_PRODUCT && use_const && !base_signed
		|-> prod[PROD_W-1:DATA_W+SHORT_W] == '0)
		else $error("literal product went negative");
	low_word_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		accept && op == OP_PRODUCT_LOW && !periph_access
		|=> wb_en && !wb_hi_en && ready && wb_lo == $past(prod[DATA_W-1:0]))
		else $error("low word product wrong");
	negate_val_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		accept && op == OP_SIGN_INVERT
		|=> wb_lo == DATA_ZERO - $past(source_working_reg) && status == $past(neg_flags))
		else $error("negate result wrong");
	pop_double_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		accept && op == OP_POP_DOUBLE && !periph_access
		|=> stk_pop && !ready ##1 stk_pop && ready)
		else $error("double pop timing wrong");
	push_double_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		accept && op == OP_PUSH_DOUBLE && !periph_access
		|=> stk_push && $stable(status) ##1 stk_push && ready
		&& stk_push_data == $past(source_hi_reg, 2))
		else $error("double push wrong");
	shadow_back_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		accept && op == OP_PUSH_SHADOW ##1 (accept && op == OP_POP_SHADOW)
		|=> status == $past(status, 2))
		else $error("shadow restore wrong");
	call_cycles_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		accept && op == OP_RELATIVE_CALL && !periph_access
		|=> !ready [*3] ##1 ready && stack_frame_active_flag)
		else $error("call length wrong");
	periph_extra_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		accept && (op == OP_OTHER || op == OP_POP) && periph_access
		|=> !ready ##1 ready)
		else $error("peripheral stall wrong");
	loop_load_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		accept && op == OP_REPEAT && !count_from_reg
		|=> repeat_left == $past(long_const_operand))
		else $error("loop count not loaded");
endmodule : msc_exec
`default_nettype wire

// file: test/cpu_multiply_stack_control_ops_bench.sv
`default_nettype none
module cpu_multiply_stack_control_ops_bench
	import msc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Stimulus and observed signals
	logic              clk_sys, sys_rst, issue, base_signed, src_signed, use_const;
	logic              acc_sel, count_from_reg, power_select_const, periph_access;
	logic              short_return, wdt_timeout_evt;
	msc_op_e           op;
	msc_dest_e         dest_kind, wb_kind;
	logic [IDX_W-1:0]  dest_idx, wb_idx;
	logic [DATA_W-1:0] base_working_reg, source_working_reg, source_hi_reg;
	logic [DATA_W-1:0] stack_top, stack_next, wb_lo, wb_hi, stk_push_data;
	logic [SHORT_W-1:0] short_const_operand;
	logic [LONG_W-1:0] long_const_operand, repeat_left;
	logic              ready, wb_en, wb_hi_en, acc_en, acc_sel_out, stk_push, stk_pop;
	logic [ACC_W-1:0]  acc_data;
	logic [STAT_W-1:0] status, exp_stat;
	logic              sleep_req, idle_req, watchdog_timeout_flag, sleep_flag;
	logic              stack_frame_active_flag, repeat_active;
	int                num_errors, n_compared;

	msc_exec dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .issue(issue), .op(op),
		.base_signed(base_signed), .src_signed(src_signed), .use_const(use_const),
		.dest_kind(dest_kind), .dest_idx(dest_idx), .acc_sel(acc_sel),
		.base_working_reg(base_working_reg), .source_working_reg(source_working_reg),
		.source_hi_reg(source_hi_reg), .short_const_operand(short_const_operand),
		.long_const_operand(long_const_operand), .count_from_reg(count_from_reg),
		.stack_top(stack_top), .stack_next(stack_next),
		.power_select_const(power_select_const), .periph_access(periph_access),
		.short_return(short_return), .wdt_timeout_evt(wdt_timeout_evt), .ready(ready),
		.wb_en(wb_en), .wb_kind(wb_kind), .wb_idx(wb_idx), .wb_lo(wb_lo),
		.wb_hi_en(wb_hi_en), .wb_hi(wb_hi), .acc_en(acc_en), .acc_sel_out(acc_sel_out),
		.acc_data(acc_data), .stk_push(stk_push), .stk_push_data(stk_push_data),
		.stk_pop(stk_pop), .status(status), .sleep_req(sleep_req), .idle_req(idle_req),
		.watchdog_timeout_flag(watchdog_timeout_flag), .sleep_flag(sleep_flag),
		.stack_frame_active_flag(stack_frame_active_flag),
		.repeat_active(repeat_active), .repeat_left(repeat_left)
	);

	// ==========================================
	// Shared helpers
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Wait a falling edge first so issue never toggles twice in one step
	task automatic start(input msc_op_e o);
		@(negedge clk_sys);
		op = o;
		issue = 1'b1;
		@(negedge clk_sys);
		issue = 1'b0;
	endtask : start

	task automatic wait_idle(output int n);
		n = 0;
		while (ready !== 1'b1 && n < 20) begin
			n++;
			@(negedge clk_sys);
		end
	endtask : wait_idle

	// Both operands widened by their own signedness, then multiplied
	function automatic logic [32:0] exp_prod(input logic [15:0] a, input logic [15:0] b,
			input logic as, input logic bs);
		logic signed [33:0] xa, xb, p;
		xa = {{18{as & a[15]}}, a};
		xb = {{18{bs & b[15]}}, b};
		p = xa * xb;
		return p[32:0];
	endfunction : exp_prod

	task automatic report_and_stop;
		if (num_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	// ==========================================
	// Scenarios
	task automatic t_negate;
		logic [15:0] ins [3] = '{16'h8000, 16'h0001, 16'h0000};
		logic [15:0] res [3] = '{16'h8000, 16'hFFFF, 16'h0000};
		logic [4:0]  fl  [3] = '{5'h0E, 5'h04, 5'h13};
		dest_kind = DK_DEFAULT;
		for (int i = 0; i < 3; i++) begin
			source_working_reg = ins[i];
			start(OP_SIGN_INVERT);
			check("neg value", wb_lo, res[i]);
			check("neg flags", status, fl[i]);
			check("neg target", {wb_en, wb_kind}, {1'b1, DK_DEFAULT});
		end
		exp_stat = 5'h13;
	endtask : t_negate

	task automatic t_product;
		logic [32:0] p;
		base_working_reg = 16'h8003;
		source_working_reg = 16'hFFFE;
		acc_sel = 1'b1;
		dest_idx = 4'h6;
		for (int i = 0; i < 8; i++) begin
			base_signed = i[1];
			src_signed = i[0];
			dest_kind = i[2] ? DK_ACC : DK_PAIR;
			p = exp_prod(16'h8003, 16'hFFFE, i[1], i[0]);
			start(OP_PRODUCT);
			check("ready after product", ready, 1'b1);
			if (i[2]) begin
				check("acc data", acc_data, {{7{p[32]}}, p});
				check("acc strobe", {acc_en, acc_sel_out}, 2'b11);
				check("acc flags", status, exp_stat);
			end else begin
				check("pair words", {wb_hi, wb_lo}, p[31:0]);
				check("pair strobes", {wb_en, wb_hi_en, wb_idx}, 6'h36);
			end
			dest_kind = DK_SINGLE;
			start(OP_PRODUCT_LOW);
			check("low word", {wb_en, wb_hi_en, wb_lo}, {2'b10, p[15:0]});
		end
	endtask : t_product

	task automatic t_const;
		logic [32:0] p;
		use_const = 1'b1;
		src_signed = 1'b1;
		base_working_reg = 16'h8000;
		short_const_operand = 5'h1F;
		for (int i = 0; i < 2; i++) begin
			base_signed = i[0];
			dest_kind = DK_PAIR;
			p = exp_prod(16'h8000, 16'h001F, i[0], 1'b0);
			start(OP_PRODUCT);
			check("const pair", {wb_hi, wb_lo}, p[31:0]);
			dest_kind = DK_ACC;
			start(OP_PRODUCT);
			check("const acc", acc_data, {{7{p[32]}}, p});
			dest_kind = DK_SINGLE;
			start(OP_PRODUCT);
			check("const single", {wb_hi_en, wb_lo}, {1'b0, p[15:0]});
			check("const ready", ready, 1'b1);
		end
		use_const = 1'b0;
	endtask : t_const

	task automatic t_stack;
		stack_top = 16'h1234;
		stack_next = 16'h2222;
		dest_kind = DK_FILE;
		start(OP_POP);
		check("pop", {stk_pop, ready, wb_en, wb_lo}, {3'b111, 16'h1234});
		check("pop kind", wb_kind, DK_FILE);
		check("pop flags", status, exp_stat);
		source_working_reg = 16'hABCD;
		start(OP_PUSH);
		check("push", {stk_push, ready, stk_push_data}, {2'b11, 16'hABCD});
		check("push flags", status, exp_stat);
		dest_kind = DK_PAIR;
		// Issue stays high into the busy cycle, where it must be ignored
		@(negedge clk_sys);
		op = OP_POP_DOUBLE;
		issue = 1'b1;
		@(negedge clk_sys);
		op = OP_PUSH;
		check("dpop c1", {stk_pop, ready, wb_hi_en}, 3'b101);
		check("dpop words", {wb_hi, wb_lo}, 32'h1234_2222);
		@(negedge clk_sys);
		issue = 1'b0;
		check("dpop c2", {stk_pop, stk_push, ready}, 3'b101);
		source_working_reg = 16'h3333;
		source_hi_reg = 16'h4444;
		start(OP_PUSH_DOUBLE);
		check("dpush c1", {stk_push, ready, stk_push_data}, {2'b10, 16'h3333});
		@(negedge clk_sys);
		check("dpush c2", {stk_push, ready, stk_push_data}, {2'b11, 16'h4444});
	endtask : t_stack

	task automatic t_shadow;
		start(OP_PUSH_SHADOW);
		check("shadow save ready", ready, 1'b1);
		source_working_reg = 16'h8000;
		start(OP_SIGN_INVERT);
		check("flags changed", status, 5'h0E);
		start(OP_POP_SHADOW);
		check("shadow restore", {ready, status}, {1'b1, exp_stat});
		// Save then restore in adjacent cycles must hand back the fresh copy
		start(OP_SIGN_INVERT);
		@(negedge clk_sys);
		op = OP_PUSH_SHADOW;
		issue = 1'b1;
		@(negedge clk_sys);
		op = OP_POP_SHADOW;
		@(negedge clk_sys);
		issue = 1'b0;
		check("shadow back to back", {ready, status}, 6'h2E);
		exp_stat = 5'h0E;
	endtask : t_shadow

	task automatic t_power;
		wdt_timeout_evt = 1'b1;
		@(negedge clk_sys);
		wdt_timeout_evt = 1'b0;
		check("watchdog set", watchdog_timeout_flag, 1'b1);
		power_select_const = 1'b0;
		start(OP_LOW_POWER);
		check("sleep entry", {sleep_req, idle_req, sleep_flag}, 3'b101);
		check("watchdog clr", {watchdog_timeout_flag, ready}, 2'b01);
		power_select_const = 1'b1;
		start(OP_LOW_POWER);
		check("idle entry", {sleep_req, idle_req}, 2'b01);
	endtask : t_power

	task automatic t_repeat;
		long_const_operand = 15'h0003;
		start(OP_REPEAT);
		check("loop count", {repeat_active, repeat_left}, {1'b1, 15'h0003});
		start(OP_PUSH);
		check("loop step", repeat_left, 15'h0002);
		count_from_reg = 1'b1;
		source_working_reg = 16'h8005;
		start(OP_REPEAT);
		check("loop from reg", {ready, repeat_left}, {1'b1, 15'h0005});
		count_from_reg = 1'b0;
	endtask : t_repeat

	task automatic t_timing;
		msc_op_e ops [4] = '{OP_POP, OP_RELATIVE_CALL, OP_IRET, OP_IRET};
		int      extra [4] = '{1, 3, 5, 4};
		int      n;
		for (int i = 0; i < 4; i++) begin
			periph_access = (i == 0);
			short_return = (i == 3);
			start(ops[i]);
			if (i == 1) begin
				check("frame set", stack_frame_active_flag, 1'b1);
			end
			if (i == 2) begin
				check("frame clr", stack_frame_active_flag, 1'b0);
			end
			wait_idle(n);
			check("busy cycles", 40'(n), 40'(extra[i]));
		end
		periph_access = 1'b0;
		short_return = 1'b0;
	endtask : t_timing

	// ==========================================
	// Main sequence and hang guard
	initial begin
		num_errors = 0;
		n_compared = 0;
		{sys_rst, issue, base_signed, src_signed, use_const, acc_sel} = 6'h20;
		{count_from_reg, power_select_const, periph_access, short_return} = 4'h0;
		wdt_timeout_evt = 1'b0;
		op = OP_OTHER;
		dest_kind = DK_SINGLE;
		dest_idx = 4'h0;
		{base_working_reg, source_working_reg, source_hi_reg} = 48'h0;
		{stack_top, stack_next} = 32'h0;
		short_const_operand = 5'h00;
		long_const_operand = 15'h0000;
		exp_stat = 5'h00;
		repeat (10) @(negedge clk_sys);
		sys_rst = 1'b0;
		t_negate();
		t_product();
		t_const();
		t_stack();
		t_shadow();
		t_power();
		t_repeat();
		t_timing();
		report_and_stop();
	end

	// Whole run is a little over a hundred cycles; allow ample margin
	initial begin
		#100000;
		num_errors++;
		report_and_stop();
	end
endmodule : cpu_multiply_stack_control_ops_bench
`default_nettype wire
